// ===== logic/psd_ctrl.sv
// event stop mask, mode and discharge control, switching clock configuration
`timescale 1ns/10ps
`default_nettype none
`include "psd_defs.svh"

// Behaviour
// [RULE_01] bit 8 lets a reverse current event stop the power train
// [RULE_02] bits 7 and 6 gate input overvoltage and undervoltage stops
// [RULE_03] bits 5 and 4 gate output overvoltage and undervoltage stops
// [RULE_04] bits 3 and 2 gate input and output overcurrent stops
// [RULE_05] bits 1 and 0 gate output short-circuit and overload stops
// [RULE_06] unimplemented upper bits read zero and ignore writes
// [RULE_07] manual discharge bit starts a discharge and self-clears when done
// [RULE_08] manual discharge request ignored while automatic discharge is set
// [RULE_09] with automatic discharge set, every power train stop starts a discharge; code starts one only on a stop rising while no discharge runs
// [RULE_10] mode codes: fault, standby, normal, discharge; discharge codes read-only
// [RULE_11] enable pin high reads normal mode and ignores standby writes
// [RULE_12] clock register ignores writes while enabled or timed function active
// [RULE_13] software keeps sync pin non-output and disabled-state readings off first
// [RULE_14] auto-revert bit returns to internal clock when sync is lost
// [RULE_15] clock output drives sync pin only when enabled and internal selected
// [RULE_16] clock source bit: 0 sync pin, 1 internal oscillator, reset 1
// [RULE_17] low eight clock register bits hold the switching period count
// [RULE_18] event stop register ignores writes while the device is enabled
// [RULE_19] stop request is OR of events with their enable bits, every cycle
// [RULE_20] mode reads discharge code during discharge, standby after normal end
module psd_ctrl (
  input wire logic sys_clk,                  // 20 MHz clock
  input wire logic resetn,                   // synchronous reset, active low
  input wire logic reg_wr,                   // register write strobe
  input wire logic [1:0] reg_sel,            // register index
  input wire logic [15:0] reg_wdata,         // write data
  output logic [15:0] reg_rdata,             // read data, one cycle after select
  input wire logic enable_pin,               // device enable pin
  input wire logic timed_func_active,        // a time-dependent function runs
  input wire logic [8:0] prot_event,         // protection events, bit = mask bit
  input wire logic discharge_done,           // power stage: discharge finished
  input wire logic discharge_fault,          // power stage: discharge failed
  input wire logic sync_lost,                // external sync missing
  input wire logic sync_in,                  // sync pin input level
  input wire logic sw_freq_in,               // internal switching frequency
  output logic stop_req,                     // stop the power train
  output logic discharge_on,                 // drive output discharge
  output logic pll_internal,                 // pll input is internal oscillator
  output logic pll_ref,                      // selected pll reference
  output logic sync_out,                     // sync pin output level
  output logic sync_oe_n,                    // sync pin drive, low drives
  output logic [7:0] switching_period_count, // period count to the pwm
  output logic [1:0] operating_mode_field    // mode as seen by software
);

  logic [8:0] event_stop_mask_ff;
  logic auto_discharge_en_ff;
  logic manual_discharge_start_ff;
  logic [1:0] mode_ff;
  logic clock_auto_revert_ff;
  logic clock_output_en_ff;
  logic pll_input_select_ff;
  logic [7:0] period_ff;
  logic reverted_ff;
  logic stop_ff;
  logic sync_out_ff;
  logic sync_oe_n_ff;
  logic pll_ref_ff;
  logic [15:0] rdata_ff;
  psd_pkg::psd_dis_e dis_ff;
  logic dev_enabled;
  logic wr_ev;
  logic wr_mode;
  logic wr_clk;
  logic stop_now;
  logic stop_rise;
  logic manual_ok;
  logic dis_start;
  logic dis_end;
  logic eff_internal;
  logic [1:0] mode_view;
  logic [15:0] nxt_rdata;

  // reset words kept whole so that single fields are picked by position
  localparam logic [15:0] EVMASK_RST = `PSD_EVMASK_RST;
  localparam logic [15:0] MODE_RST = `PSD_MODE_RST;
  localparam logic [15:0] CLK_RST = `PSD_CLK_RST;

  assign dev_enabled = enable_pin || (mode_ff == `PSD_OPM_NORMAL);
  assign wr_ev = reg_wr && (reg_sel == `PSD_IDX_EVMASK);
  assign wr_mode = reg_wr && (reg_sel == `PSD_IDX_MODE);
  assign wr_clk = reg_wr && (reg_sel == `PSD_IDX_CLK);

  // [RULE_18] no mask change while enabled
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      event_stop_mask_ff <= EVMASK_RST[`PSD_EV_COUNT-1:0];
    end else if (wr_ev && !dev_enabled) begin
      // [RULE_06] only the nine mask bits are stored
      event_stop_mask_ff <= reg_wdata[`PSD_EV_COUNT-1:0];
    end
  end

  // [RULE_01] each event gated by its own enable bit, covering bits 8..0
  // [RULE_02] [RULE_03] [RULE_04] [RULE_05] bits 7..0 gated alike
  // [RULE_19] registered OR of gated events, recomputed every cycle
  assign stop_now = |(prot_event & event_stop_mask_ff);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stop_ff <= 1'b0;
    end else begin
      stop_ff <= stop_now;
    end
  end

  assign stop_req = stop_ff;
  // a held event stops once; the discharge follows its first cycle only
  assign stop_rise = stop_now && !stop_ff;

  // [RULE_08] manual request only counts with automatic discharge clear
  assign manual_ok = wr_mode && reg_wdata[`PSD_MODE_MANUAL_BIT]
                     && !reg_wdata[`PSD_MODE_AUTO_BIT] && !auto_discharge_en_ff;
  // [RULE_09] a stop launches a discharge when automatic discharge is set
  assign dis_start = (dis_ff == psd_pkg::PSD_DIS_IDLE)
                     && (manual_ok || (stop_rise && auto_discharge_en_ff));
  assign dis_end = (dis_ff == psd_pkg::PSD_DIS_BUSY) && (discharge_done || discharge_fault);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dis_ff <= psd_pkg::PSD_DIS_IDLE;
    end else begin
      case (dis_ff)
        psd_pkg::PSD_DIS_IDLE: begin
          if (dis_start) begin
            dis_ff <= psd_pkg::PSD_DIS_BUSY;
          end
        end
        psd_pkg::PSD_DIS_BUSY: begin
          if (dis_end) begin
            dis_ff <= psd_pkg::PSD_DIS_IDLE;
          end
        end
        default: begin
          dis_ff <= psd_pkg::PSD_DIS_IDLE;
        end
      endcase
    end
  end

  assign discharge_on = (dis_ff == psd_pkg::PSD_DIS_BUSY);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      auto_discharge_en_ff <= MODE_RST[`PSD_MODE_AUTO_BIT];
    end else if (wr_mode) begin
      auto_discharge_en_ff <= reg_wdata[`PSD_MODE_AUTO_BIT];
    end
  end

  // [RULE_07] set by an honoured request, cleared by hardware at the end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      manual_discharge_start_ff <= 1'b0;
    end else if (dis_start && manual_ok) begin
      manual_discharge_start_ff <= 1'b1;
    end else if (dis_end) begin
      manual_discharge_start_ff <= 1'b0;
    end
  end

  // [RULE_10] software may write only standby or normal
  // [RULE_20] discharge code while busy, standby or fault afterwards
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_ff <= `PSD_OPM_STANDBY;
    end else if (dis_start) begin
      mode_ff <= `PSD_OPM_DISCH;
    end else if (dis_end) begin
      mode_ff <= discharge_fault ? `PSD_OPM_FAULT : `PSD_OPM_STANDBY;
    end else if (wr_mode && !discharge_on) begin
      if (reg_wdata[1:0] == `PSD_OPM_NORMAL) begin
        mode_ff <= `PSD_OPM_NORMAL;
      // [RULE_11] standby refused while the enable pin is high
      end else if (reg_wdata[1:0] == `PSD_OPM_STANDBY && !enable_pin) begin
        mode_ff <= `PSD_OPM_STANDBY;
      end
    end
  end

  // [RULE_11] pin high shows normal unless a discharge is under way
  assign mode_view = (enable_pin && !discharge_on && mode_ff != `PSD_OPM_DISCH)
                     ? `PSD_OPM_NORMAL : mode_ff;
  assign operating_mode_field = mode_view;

  // [RULE_12] clock config frozen while enabled or timed function active
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clock_auto_revert_ff <= CLK_RST[`PSD_CLK_REVERT_BIT];
      clock_output_en_ff <= CLK_RST[`PSD_CLK_OUTEN_BIT];
      pll_input_select_ff <= CLK_RST[`PSD_CLK_SRC_BIT];
      period_ff <= CLK_RST[7:0];
    end else if (wr_clk && !dev_enabled && !timed_func_active) begin
      clock_auto_revert_ff <= reg_wdata[`PSD_CLK_REVERT_BIT];
      clock_output_en_ff <= reg_wdata[`PSD_CLK_OUTEN_BIT];
      // [RULE_16] source select, internal after reset
      pll_input_select_ff <= reg_wdata[`PSD_CLK_SRC_BIT];
      // [RULE_17] period count stored as written
      period_ff <= reg_wdata[7:0];
    end
  end

  assign switching_period_count = period_ff;

  // [RULE_14] sticky revert; a fresh config write re-arms external sync
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reverted_ff <= 1'b0;
    end else if (sync_lost && clock_auto_revert_ff && !pll_input_select_ff) begin
      reverted_ff <= 1'b1;
    end else if (wr_clk && !dev_enabled && !timed_func_active) begin
      reverted_ff <= 1'b0;
    end
  end

  assign eff_internal = pll_input_select_ff || reverted_ff;
  assign pll_internal = eff_internal;

  // [RULE_15] drive the switching frequency only on internal source
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync_out_ff <= 1'b0;
      sync_oe_n_ff <= 1'b1;
      pll_ref_ff <= 1'b0;
    end else begin
      sync_out_ff <= sw_freq_in;
      sync_oe_n_ff <= !(clock_output_en_ff && eff_internal);
      pll_ref_ff <= eff_internal ? sw_freq_in : sync_in;
    end
  end

  assign sync_out = sync_out_ff;
  assign sync_oe_n = sync_oe_n_ff;
  assign pll_ref = pll_ref_ff;

  // [RULE_06] unimplemented bits are zero in every read word
  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_sel)
      `PSD_IDX_EVMASK: begin
        nxt_rdata = {7'h00, event_stop_mask_ff};
      end
      `PSD_IDX_MODE: begin
        nxt_rdata = {6'h00, manual_discharge_start_ff, auto_discharge_en_ff, 6'h00, mode_view};
      end
      `PSD_IDX_CLK: begin
        nxt_rdata = {5'h00, clock_auto_revert_ff, clock_output_en_ff, pll_input_select_ff,
                     period_ff};
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // checks
  logic past_valid_ff;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      past_valid_ff <= 1'b0;
    end else begin
      past_valid_ff <= 1'b1;
    end
  end

  chk_stop_gating: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_19]
    past_valid_ff |-> stop_req == |($past(prot_event) & $past(event_stop_mask_ff)))
    else $error("stop request does not match gated events");

  chk_reverse_mask: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_01]
    (prot_event == 9'h100 && !event_stop_mask_ff[8]) |=> !stop_req)
    else $error("masked reverse current stopped the power train");

  chk_mask_lock: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_18]
    (wr_ev && dev_enabled) |=> $stable(event_stop_mask_ff))
    else $error("event mask changed while enabled");

  chk_clk_lock: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_12]
    (wr_clk && (dev_enabled || timed_func_active)) |=> $stable(period_ff)
    && $stable(pll_input_select_ff))
    else $error("clock config changed while locked");

  chk_manual_ignored: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_08]
    (wr_mode && auto_discharge_en_ff && !stop_rise) |=> !$rose(discharge_on))
    else $error("manual discharge accepted with auto discharge set");

  chk_auto_launch: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_09]
    (stop_rise && auto_discharge_en_ff && !discharge_on) |=> discharge_on
    && mode_ff == `PSD_OPM_DISCH)
    else $error("stop did not launch discharge");

  chk_manual_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07]
    (discharge_on && discharge_done) |=> !manual_discharge_start_ff && !discharge_on
    && mode_ff == `PSD_OPM_STANDBY)
    else $error("discharge end not reflected");

  chk_enable_view: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_11]
    (enable_pin && !discharge_on) |-> operating_mode_field == `PSD_OPM_NORMAL)
    else $error("enable pin high but mode not normal");

  chk_disch_view: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_20]
    discharge_on |-> operating_mode_field == `PSD_OPM_DISCH)
    else $error("discharge under way but mode not discharge");

  chk_code_ro: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_10]
    (wr_mode && !discharge_on && !dis_start && (reg_wdata[1:0] == `PSD_OPM_FAULT
    || reg_wdata[1:0] == `PSD_OPM_DISCH)) |=> $stable(mode_ff))
    else $error("read-only mode code was written");

  chk_sync_drive: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_15]
    !sync_oe_n |-> $past(clock_output_en_ff) && $past(eff_internal))
    else $error("sync pin driven without internal clock output");

  chk_sync_idle: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_15]
    (!clock_output_en_ff || !eff_internal) |=> sync_oe_n)
    else $error("sync pin not released");

  chk_revert: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_14]
    (sync_lost && !clock_auto_revert_ff) |=> pll_internal == $past(pll_internal)
    || $past(wr_clk))
    else $error("clock reverted with auto revert off");

  cov_manual: cover property (@(posedge sys_clk) disable iff (!resetn)
    manual_ok ##1 discharge_on ##[1:20] !discharge_on);
  cov_auto: cover property (@(posedge sys_clk) disable iff (!resetn)
    stop_rise && auto_discharge_en_ff ##1 discharge_on);
  cov_revert: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(reverted_ff));
  cov_clkout: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(sync_oe_n));

endmodule
`default_nettype wire

// ===== logic/psd_defs.svh
// register indices, field positions, reset values and codes of the power stop block
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

`define PSD_IDX_EVMASK 2'h0
`define PSD_IDX_MODE 2'h1
`define PSD_IDX_CLK 2'h2

`define PSD_EVMASK_RST 16'h0000
`define PSD_EVMASK_BITS 16'h01ff
`define PSD_EV_COUNT 9

`define PSD_MODE_RST 16'h0101
`define PSD_MODE_MASK 16'h0303
`define PSD_MODE_MANUAL_BIT 9
`define PSD_MODE_AUTO_BIT 8
`define PSD_MODE_FIELD_LSB 0

`define PSD_CLK_RST 16'h014f
`define PSD_CLK_MASK 16'h07ff
`define PSD_CLK_REVERT_BIT 10
`define PSD_CLK_OUTEN_BIT 9
`define PSD_CLK_SRC_BIT 8

`define PSD_OPM_FAULT 2'h0
`define PSD_OPM_STANDBY 2'h1
`define PSD_OPM_NORMAL 2'h2
`define PSD_OPM_DISCH 2'h3

`endif

// ===== logic/psd_pkg.sv
// types shared by the power stop block
package psd_pkg;
  typedef enum logic {
    PSD_DIS_IDLE,
    PSD_DIS_BUSY
  } psd_dis_e;
  typedef logic [15:0] psd_word_t;
endpackage

// ===== dv/psd_stage_model.sv
// power stage stand-in that ends each output discharge, normally or with a fault
`timescale 1ns/10ps
`default_nettype none
module psd_stage_model #(
  parameter int DLY = 8
) (
  input wire logic sys_clk,      // bench clock
  input wire logic resetn,       // synchronous reset, active low
  input wire logic discharge_on, // discharge drive from the block
  input wire logic fault_mode,   // end discharges with a fault
  output logic discharge_done,   // one-cycle normal end
  output logic discharge_fault   // one-cycle failed end
);
  int cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !discharge_on) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  // one pulse per discharge, so a late drop of the drive cannot retrigger
  always_ff @(posedge sys_clk) begin
    discharge_done <= resetn && discharge_on && cnt_ff == DLY - 1 && !fault_mode;
    discharge_fault <= resetn && discharge_on && cnt_ff == DLY - 1 && fault_mode;
  end
endmodule
`default_nettype wire

// ===== dv/psd_ctrl_test.sv
// self-checking bench of the stop mask, discharge and switching clock block
`timescale 1ns/10ps
`default_nettype none
module psd_ctrl_test;
  logic sys_clk, resetn, reg_wr, enable_pin, timed_func_active, sync_lost, sync_in, sw_freq_in;
  logic discharge_done, discharge_fault, stop_req, discharge_on, pll_internal, pll_ref;
  logic sync_out, sync_oe_n, fault_mode;
  logic [1:0] reg_sel;
  logic [1:0] opm;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [8:0] prot_event;
  logic [7:0] spc;
  int bad_count;
  int checked;

  psd_ctrl u_psd_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
    .timed_func_active(timed_func_active), .prot_event(prot_event),
    .discharge_done(discharge_done), .discharge_fault(discharge_fault),
    .sync_lost(sync_lost), .sync_in(sync_in), .sw_freq_in(sw_freq_in),
    .stop_req(stop_req), .discharge_on(discharge_on), .pll_internal(pll_internal),
    .pll_ref(pll_ref), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
    .switching_period_count(spc), .operating_mode_field(opm)
  );
  psd_stage_model #(.DLY(8)) u_psd_stage_model (
    .sys_clk(sys_clk), .resetn(resetn), .discharge_on(discharge_on),
    .fault_mode(fault_mode), .discharge_done(discharge_done),
    .discharge_fault(discharge_fault)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // read data is registered, so it is looked at one cycle after the select
  task automatic rd_chk(input logic [1:0] sel, input logic [15:0] exp);
    @(negedge sys_clk);
    reg_sel = sel;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic wait_dis(input logic v);
    int n;
    n = 0;
    while (discharge_on !== v && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (discharge_on !== v) begin
      bad_count++;
      close_out();
    end
  endtask

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 16'h0000;
    enable_pin = 1'b0;
    timed_func_active = 1'b0;
    prot_event = 9'h000;
    sync_lost = 1'b0;
    sync_in = 1'b0;
    sw_freq_in = 1'b0;
    fault_mode = 1'b0;
    bad_count = 0;
    checked = 0;
    cyc(8);
    resetn = 1'b1;
    rd_chk(2'h0, 16'h0000); // mask reset
    rd_chk(2'h1, 16'h0101); // mode reset
    rd_chk(2'h2, 16'h014f); // clock reset
    rd_chk(2'h3, 16'h0000); // unmapped reads zero
    chk(pll_internal, 1'b1); // internal after reset
    chk(sync_oe_n, 1'b1); // sync pin idle
    // clock output stays off until the last clock change
    wr(2'h2, 16'h0400);
    sync_in = 1'b1;
    cyc(2);
    chk(pll_internal, 1'b0); // sync pin source
    chk(pll_ref, 1'b1); // reference from sync pin
    sync_lost = 1'b1;
    cyc(3);
    chk(pll_internal, 1'b1); // reverted on loss
    sync_lost = 1'b0;
    wr(2'h2, 16'h0000);
    chk(pll_internal, 1'b0); // accepted write re-arms sync
    sync_lost = 1'b1;
    cyc(3);
    chk(pll_internal, 1'b0); // no revert
    sync_lost = 1'b0;
    wr(2'h2, 16'hffff);
    sync_in = 1'b0;
    sw_freq_in = 1'b1;
    cyc(2);
    chk(spc, 16'h00ff); // period count
    chk(sync_oe_n, 1'b0); // sync pin driven
    chk(sync_out, 1'b1); // frequency on pin
    chk(pll_ref, 1'b1); // internal reference
    rd_chk(2'h2, 16'h07ff); // clock fields readable
    timed_func_active = 1'b1;
    wr(2'h2, 16'h0150);
    rd_chk(2'h2, 16'h07ff); // locked by timed function
    timed_func_active = 1'b0;
    enable_pin = 1'b1;
    wr(2'h2, 16'h0150);
    wr(2'h0, 16'h0001);
    wr(2'h1, 16'h0101);
    rd_chk(2'h2, 16'h07ff); // locked while enabled
    rd_chk(2'h0, 16'h0000); // mask locked while enabled
    rd_chk(2'h1, 16'h0102); // pin reads normal
    enable_pin = 1'b0;
    rd_chk(2'h1, 16'h0101); // standby write had no effect
    wr(2'h1, 16'h0003);
    rd_chk(2'h1, 16'h0001); // discharge code not writable
    wr(2'h1, 16'h0000);
    rd_chk(2'h1, 16'h0001); // fault code not writable
    wr(2'h1, 16'h0002);
    rd_chk(2'h1, 16'h0002); // normal accepted
    enable_pin = 1'b1;
    wr(2'h1, 16'h0001);
    enable_pin = 1'b0;
    rd_chk(2'h1, 16'h0002); // standby refused under pin
    wr(2'h0, 16'h0001);
    rd_chk(2'h0, 16'h0000); // mask locked in normal mode
    wr(2'h1, 16'hfc01);
    rd_chk(2'h1, 16'h0001); // upper mode bits read zero
    wr(2'h0, 16'hffff);
    rd_chk(2'h0, 16'h01ff); // upper mask bits read zero
    for (int i = 0; i < 9; i++) begin
      wr(2'h0, 16'h0001 << i);
      prot_event = ~(9'h001 << i);
      cyc(2);
      chk(stop_req, 1'b0); // masked events ignored
      prot_event = 9'h001 << i;
      cyc(2);
      chk(stop_req, 1'b1); // gated stop
    end
    chk(discharge_on, 1'b0); // no discharge without auto
    prot_event = 9'h000;
    wr(2'h1, 16'h0201);
    chk(discharge_on, 1'b1); // manual start
    chk(opm, 16'h0003); // discharge code
    rd_chk(2'h1, 16'h0203); // busy reads discharge
    wait_dis(1'b0);
    rd_chk(2'h1, 16'h0001); // self-clear and standby
    wr(2'h1, 16'h0301);
    cyc(2);
    chk(discharge_on, 1'b0); // manual ignored under auto
    rd_chk(2'h1, 16'h0101); // manual bit not kept
    prot_event = 9'h100;
    wait_dis(1'b1);
    chk(discharge_on, 1'b1); // stop discharges
    wait_dis(1'b0);
    rd_chk(2'h1, 16'h0101); // back to standby
    prot_event = 9'h000;
    fault_mode = 1'b1;
    cyc(2);
    prot_event = 9'h100;
    wait_dis(1'b1);
    wait_dis(1'b0);
    rd_chk(2'h1, 16'h0100); // discharge fault code
    prot_event = 9'h000;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    rd_chk(2'h2, 16'h014f); // second reset
    rd_chk(2'h1, 16'h0101); // fault mode cleared by reset
    close_out();
  end
endmodule
`default_nettype wire
